// ### bench/printer_model.sv
/*
  Printer-side model: status lines, the enhanced wait handshake and the
  byte offered when the port reads the cable. Assumes the bench sets
  line_state, reply_byte and hold_wait between accesses.
*/
`timescale 1ns/1ps
module printer_model (
  input  wire logic       sys_clk,            // System clock
  input  wire logic [4:0] line_state,         // busy, ack_n, paper, online, fault_n
  input  wire logic [7:0] reply_byte,         // Byte driven when port listens
  input  wire logic       hold_wait,          // Never release wait
  input  wire logic       io_channel_ready,   // Low while a cycle is stretched
  input  wire logic [7:0] cable_data_out,     // Port drive value
  input  wire logic       cable_data_oe,      // Port drives the cable
  output      logic [7:0] cable_data_in,      // Resolved cable level
  output      logic       peripheral_wait_n,  // High = released
  output      logic       printer_fault_in_n, // Fault, active low
  output      logic       printer_online_in,  // On line
  output      logic       paper_out_in,       // Paper exhausted
  output      logic       printer_ack_in_n,   // Acknowledge, active low
  output      logic       printer_busy_in     // Busy
);
  logic [3:0] wait_cnt = 4'h0;

  // Status lines follow the state the bench asks for
  assign {printer_busy_in, printer_ack_in_n, paper_out_in, printer_online_in, printer_fault_in_n} = line_state;

  // Peripheral drives its byte only while the port has let go
  assign cable_data_in = cable_data_oe ? cable_data_out : reply_byte;

  // Wait is held low at rest and released a few cycles into a cycle; a stall never releases
  always_ff @(posedge sys_clk) begin
    if (io_channel_ready) begin
      wait_cnt          <= 4'h0;
      peripheral_wait_n <= 1'b0;
    end else begin
      wait_cnt          <= wait_cnt + 4'(wait_cnt != 4'hf);
      peripheral_wait_n <= !hold_wait && (wait_cnt >= 4'h2);
    end
  end
endmodule : printer_model

// ### bench/printer_port_registers_test.sv
/*
  Self-checking bench for the printer port registers: strobe accesses to
  all eight ports, cable mapping, enhanced cycles and the ack interrupt.
  Assumes a 50 MHz clock and the printer model on the cable side.
*/
`timescale 1ns/1ps
module printer_port_registers_test
  import pport_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] base_addr = 16'h0378;
  port_mode_t  port_mode = MODE_PRINTER;
  logic [15:0] host_addr = 16'h0378;
  logic [7:0]  host_data_in = 8'h00;
  logic        host_write_strobe_n = 1'b1;
  logic        host_read_strobe_n = 1'b1;
  logic [4:0]  line_state = 5'h0b;
  logic [7:0]  reply_byte = 8'h5a;
  logic        hold_wait = 1'b0;
  logic [7:0]  host_data_out, cable_data_out, cable_data_in, rq;
  logic        host_data_oe, io_channel_ready, ack_irq, cable_data_oe, roe, peripheral_wait_n;
  logic        printer_fault_in_n, printer_online_in, paper_out_in, printer_ack_in_n, printer_busy_in;
  logic        data_strobe_out_n, auto_linefeed_out_n, printer_init_n, select_printer_out_n;
  int          bad_count = 0, n_compared = 0, cycles = 0, irq_count = 0, lo_cnt = 0, lo_run = 0;
  logic [7:0]  vals [4] = '{8'hff, 8'h00, 8'h15, 8'h2a};

  // Clock, cycle ceiling, interrupt count and stretch length
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    irq_count += int'(ack_irq === 1'b1);
    lo_cnt = (io_channel_ready === 1'b0) ? lo_cnt + 1 : 0;
    if (lo_cnt > 0) lo_run = lo_cnt;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  printer_port_registers u_dut (.sys_clk(sys_clk), .rst(rst), .base_addr(base_addr), .port_mode(port_mode),
    .host_addr(host_addr), .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .host_write_strobe_n(host_write_strobe_n),
    .host_read_strobe_n(host_read_strobe_n), .io_channel_ready(io_channel_ready), .ack_irq(ack_irq),
    .cable_data_in(cable_data_in), .cable_data_out(cable_data_out), .cable_data_oe(cable_data_oe),
    .printer_fault_in_n(printer_fault_in_n), .printer_online_in(printer_online_in),
    .paper_out_in(paper_out_in), .printer_ack_in_n(printer_ack_in_n), .printer_busy_in(printer_busy_in),
    .peripheral_wait_n(peripheral_wait_n), .data_strobe_out_n(data_strobe_out_n),
    .auto_linefeed_out_n(auto_linefeed_out_n), .printer_init_n(printer_init_n),
    .select_printer_out_n(select_printer_out_n));

  // Ready goes straight to the host side, as the system must wire it
  printer_model u_printer (.sys_clk(sys_clk), .line_state(line_state), .reply_byte(reply_byte),
    .hold_wait(hold_wait), .io_channel_ready(io_channel_ready), .cable_data_out(cable_data_out),
    .cable_data_oe(cable_data_oe), .cable_data_in(cable_data_in), .peripheral_wait_n(peripheral_wait_n),
    .printer_fault_in_n(printer_fault_in_n), .printer_online_in(printer_online_in),
    .paper_out_in(paper_out_in), .printer_ack_in_n(printer_ack_in_n), .printer_busy_in(printer_busy_in));

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : tick

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  // One strobe access; holds the strobe until ready is back, bounded
  task automatic access(input logic wr, input logic [2:0] ofs, input logic [7:0] d);
    int guard;
    guard = 0;
    host_addr = base_addr | 16'(ofs);
    host_data_in = d;
    if (wr) host_write_strobe_n = 1'b0;
    else host_read_strobe_n = 1'b0;
    tick(2);
    while (io_channel_ready !== 1'b1 && guard < 700) begin
      tick(1);
      guard++;
    end
    tick(1);
    rq = host_data_out;
    roe = host_data_oe;
    host_write_strobe_n = 1'b1;
    host_read_strobe_n = 1'b1;
    tick(2);
  endtask : access

  function automatic logic [7:0] st(input logic [4:0] s, input logic tmo);
    return {~s[4], s[3], s[2], s[1], s[0], 2'b00, tmo};
  endfunction : st

  function automatic logic [7:0] lines(input logic [7:0] c);
    return {4'h0, ~c[0], ~c[1], c[2], ~c[3]};
  endfunction : lines

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // Main sequence: one block per test
  initial begin
    tick(8);
    rst = 1'b0;
    tick(1);
    check("data reset", 8'h00, cable_data_out);
    check("control reset", lines(8'h00), {4'h0, data_strobe_out_n, auto_linefeed_out_n, printer_init_n,
      select_printer_out_n});
    $display("test reset done");
    access(1'b1, OFS_DATA, 8'ha5);
    check("cable out", 8'ha5, cable_data_out);
    access(1'b0, OFS_DATA, 8'h00);
    check("data read", 8'ha5, rq);
    port_mode = MODE_STANDARD_BIDIR;
    access(1'b1, OFS_CONTROL, 8'h20);
    check("dir input", 8'h00, {7'h0, cable_data_oe});
    access(1'b0, OFS_DATA, 8'h00);
    check("live read", 8'h5a, rq);
    port_mode = MODE_PRINTER;
    tick(2);
    check("printer dir", 8'h01, {7'h0, cable_data_oe});
    $display("test data done");
    foreach (vals[i]) begin
      access(1'b1, OFS_CONTROL, vals[i]);
      check("lines", lines(vals[i]), {4'h0, data_strobe_out_n, auto_linefeed_out_n, printer_init_n,
        select_printer_out_n});
      access(1'b0, OFS_CONTROL, 8'h00);
      check("control read", vals[i] & 8'h3f, rq);
    end
    $display("test control done");
    foreach (vals[i]) begin
      line_state = vals[i][4:0];
      access(1'b1, OFS_STATUS, 8'hfe);
      access(1'b0, OFS_STATUS, 8'h00);
      check("status", st(line_state, 1'b0), rq);
    end
    host_addr = base_addr | 16'(OFS_STATUS);
    host_read_strobe_n = 1'b0;
    tick(3);
    line_state = 5'h15;
    tick(3);
    check("held status", st(5'h0a, 1'b0), host_data_out);
    host_read_strobe_n = 1'b1;
    tick(2);
    $display("test status done");
    for (int m = 0; m < 4; m++) begin
      port_mode = port_mode_t'(m);
      for (int o = 3; o < 8; o++) begin
        access(1'b0, 3'(o), 8'h00);
        check("enhanced answer", 8'(m == 2), {7'h0, roe});
      end
    end
    port_mode = MODE_EPP;
    access(1'b1, OFS_CONTROL, 8'h04);
    lo_run = 0;
    access(1'b1, OFS_EPP_DATA0, 8'h3c);
    check("stretched", 8'h01, 8'(lo_run > 0 && lo_run < 8));
    access(1'b0, OFS_EPP_ADDR, 8'h00);
    check("enhanced read", 8'h5a, rq);
    hold_wait = 1'b1;
    access(1'b1, OFS_EPP_DATA3, 8'h11);
    hold_wait = 1'b0;
    check("watchdog run", 8'h01, 8'(lo_run >= 500 && lo_run <= 505));
    access(1'b1, OFS_STATUS, 8'h00);
    access(1'b0, OFS_STATUS, 8'h00);
    check("timeout kept", st(line_state, 1'b1), rq);
    access(1'b1, OFS_STATUS, 8'h01);
    access(1'b0, OFS_STATUS, 8'h00);
    check("timeout cleared", st(line_state, 1'b0), rq);
    $display("test enhanced done");
    port_mode = MODE_PRINTER;
    for (int e = 1; e >= 0; e--) begin
      access(1'b1, OFS_CONTROL, 8'(e) << CTL_IRQ_EN);
      irq_count = 0;
      line_state[3] = 1'b0;
      tick(3);
      line_state[3] = 1'b1;
      tick(4);
      check("irq pulses", 8'(e), 8'(irq_count));
    end
    $display("test interrupt done");
    report_and_stop();
  end
endmodule : printer_port_registers_test

// ### hw/epp_cycle_timer.sv
/*
  Watchdog for enhanced cycles: counts while run is high and raises
  expired once more than the limit has passed. Assumes run drops when
  the cycle finishes or is aborted.
*/
`timescale 1ns/1ps
module epp_cycle_timer
  import pport_pkg::*;
(
  input  wire logic  sys_clk,  // System clock
  input  wire logic  rst,      // Async reset, active high
  epp_timer_if.tmr   tif       // Run in, expiry out
);

  logic [TMR_W-1:0] count;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Counter saturates at the limit so a stuck cycle cannot wrap
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count       <= '0;
      tif.expired <= 1'b0;
    end else if (!tif.run) begin
      count       <= '0;
      tif.expired <= 1'b0;
    end else begin
      if (count != EPP_TIMEOUT_CYCLES) begin
        count <= count + TMR_W'(1);
      end
      tif.expired <= (count == EPP_TIMEOUT_CYCLES);
    end
  end

  a_timer_expiry: assert property (
    (tif.run && count == EPP_TIMEOUT_CYCLES) |=> tif.expired
  ) else $error("watchdog did not expire at the limit");

  a_timer_early: assert property (
    $rose(tif.run) |=> !tif.expired [*8]
  ) else $error("watchdog expired too early");

endmodule : epp_cycle_timer

// ### hw/epp_timer_if.sv
/*
  Carrier between the enhanced-cycle sequencer and its watchdog timer.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface epp_timer_if;
  logic run;      // Cycle in progress, timer counts
  logic expired;  // Level: cycle ran past the limit

  modport ctl (output run, input expired);
  modport tmr (input run, output expired);
endinterface : epp_timer_if

// ### hw/pport_pkg.sv
/*
  Shared constants and types for the printer port register block:
  port offsets, bit positions, reset values, operating modes, the
  enhanced-cycle state codes and the enhanced-cycle watchdog timing.
  Assumes a 50 MHz system clock.
*/
package pport_pkg;

  // Port offsets relative to the decoded base
  localparam logic [2:0] OFS_DATA      = 3'h0;
  localparam logic [2:0] OFS_STATUS    = 3'h1;
  localparam logic [2:0] OFS_CONTROL   = 3'h2;
  localparam logic [2:0] OFS_EPP_ADDR  = 3'h3;
  localparam logic [2:0] OFS_EPP_DATA0 = 3'h4;
  localparam logic [2:0] OFS_EPP_DATA3 = 3'h7;

  // Status port bit positions
  localparam int ST_TIMEOUT = 0;
  localparam int ST_FAULT   = 3;
  localparam int ST_ONLINE  = 4;
  localparam int ST_PAPER   = 5;
  localparam int ST_ACK     = 6;
  localparam int ST_READY   = 7;

  // Control port bit positions
  localparam int CTL_STROBE = 0;
  localparam int CTL_AUTO_LINEFEED_BIT = 1;
  localparam int CTL_INIT   = 2;
  localparam int CTL_SELECT = 3;
  localparam int CTL_IRQ_EN = 4;
  localparam int CTL_DIR    = 5;
  localparam int CTL_W      = 6;

  // Reset values
  localparam logic [7:0]       DATA_RESET    = 8'h00;
  localparam logic [CTL_W-1:0] CONTROL_RESET = 6'h00;
  localparam logic [7:0]       EPP_RESET     = 8'h00;

  // Enhanced-cycle watchdog: least time, rounded up to whole cycles
  localparam int CLK_PERIOD_NS  = 20;
  localparam int EPP_TIMEOUT_NS = 10000;
  localparam int TMR_W          = 10;
  localparam logic [TMR_W-1:0] EPP_TIMEOUT_CYCLES =
    TMR_W'((EPP_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Operating mode chosen by configuration outside this block
  typedef enum logic [1:0] {
    MODE_PRINTER        = 2'h0,
    MODE_STANDARD_BIDIR = 2'h1,
    MODE_EPP            = 2'h2,
    MODE_ECP            = 2'h3
  } port_mode_t;

  // Enhanced-cycle sequencer states
  typedef enum logic [2:0] {
    EPP_IDLE = 3'b001,
    EPP_BUSY = 3'b010,
    EPP_HOLD = 3'b100
  } epp_state_t;

endpackage : pport_pkg

// ### hw/printer_port_registers.sv
/*
  Register side of a parallel printer port: eight byte ports behind an
  ISA-style strobe interface, the cable line mapping, the enhanced-cycle
  watchdog and the acknowledge interrupt. Assumes host strobes and cable
  inputs are synchronous to sys_clk and the address is stable while a
  strobe is low. Mode and base come from configuration outside.
*/
`timescale 1ns/1ps

// Function
// - Decode eight byte ports from base: data, status, control, address, four data ports.
// - Enhanced address and data ports answer only in enhanced mode; others always.
// - Data register clears on reset, loads on write strobe rising edge, drives cable.
// - Standard-mode data read returns live cable lines, not a stored copy.
// - Status byte is captured at read start and held until strobe ends.
// - Status bit 0 flags 10 us timeout; reset clears; writing one clears.
// - Status bits 1 and 2 always read zero.
// - Status bit 3 returns the active-low fault input uninverted.
// - Status bit 4 returns the printer online input.
// - Status bit 5 returns the paper-out input.
// - Status bit 6 returns the active-low acknowledge input.
// - Status bit 7 returns the inverse of the busy input.
// - Reset clears control bits 0 to 5; bits 6 and 7 read zero.
// - Control bit 0 inverted drives the data strobe line.
// - Control bit 1 inverted drives the auto-linefeed line.
// - Control bit 2 drives the printer initialise line uninverted.
// - Control bit 3 inverted drives the select-printer line.
// - With control bit 4 set, each acknowledge rising edge raises interrupt.
// - Control bit 5 sets data direction except in printer mode, always output, and during enhanced cycles, which set their own.
// - Enhanced cycle over 10 us without wait release sets timeout and aborts.
module printer_port_registers
  import pport_pkg::*;
(
  input  wire logic       sys_clk,              // System clock, 50 MHz
  input  wire logic       rst,                  // Async reset, active high
  input  wire logic [15:0] base_addr,           // Port base from configuration
  input  port_mode_t      port_mode,            // Operating mode from configuration
  input  wire logic [15:0] host_addr,           // Host I/O address
  input  wire logic [7:0] host_data_in,         // Host write data
  output      logic [7:0] host_data_out,        // Host read data
  output      logic       host_data_oe,         // Drive host data bus
  input  wire logic       host_write_strobe_n,  // Host write strobe, active low
  input  wire logic       host_read_strobe_n,   // Host read strobe, active low
  output      logic       io_channel_ready,     // Low stretches host cycle
  output      logic       ack_irq,              // Interrupt request pulse
  input  wire logic [7:0] cable_data_in,        // Cable data lines, level in
  output      logic [7:0] cable_data_out,       // Cable data lines, level out
  output      logic       cable_data_oe,        // High while driving cable data
  input  wire logic       printer_fault_in_n,   // Printer fault, active low
  input  wire logic       printer_online_in,    // Printer selected
  input  wire logic       paper_out_in,         // Paper exhausted
  input  wire logic       printer_ack_in_n,     // Acknowledge, active low
  input  wire logic       printer_busy_in,      // Printer busy
  input  wire logic       peripheral_wait_n,    // Peripheral wait line
  output      logic       data_strobe_out_n,    // Data strobe, active low
  output      logic       auto_linefeed_out_n,  // Auto linefeed, active low
  output      logic       printer_init_n,       // Initialise printer, active low
  output      logic       select_printer_out_n  // Select printer, active low
);

  logic [7:0]       printer_data_out;       // Data port register
  logic [CTL_W-1:0] printer_line_control;   // Control port, bits 0..5
  logic             enh_cycle_timeout_flag; // Status bit 0
  logic [7:0]       enh_out;                // Enhanced write byte
  logic [7:0]       enh_in;                 // Enhanced read byte
  logic             enh_is_write;           // Current enhanced cycle direction
  epp_state_t       epp_state;
  logic             wr_q;
  logic             rd_q;
  logic             ack_q;
  logic [7:0]       live_status;
  logic [7:0]       held_status;

  epp_timer_if tif ();

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Strobe edges and address decode
  wire       wr_act   = !host_write_strobe_n;
  wire       rd_act   = !host_read_strobe_n;
  wire       wr_start = wr_act && !wr_q;
  wire       rd_start = rd_act && !rd_q;
  wire       wr_end   = wr_q && !wr_act;  // Rising edge of write strobe
  wire [2:0] ofs      = host_addr[2:0];
  wire       hit      = (host_addr[15:3] == base_addr[15:3]);
  wire       enh_port = (ofs >= OFS_EPP_ADDR);
  wire       answers  = hit && (!enh_port || port_mode == MODE_EPP);
  wire       enh_go   = (wr_start || rd_start) && hit && enh_port && (port_mode == MODE_EPP);

  // Status byte as the cable shows it; bits 1 and 2 have no storage
  assign live_status = {!printer_busy_in,
                        printer_ack_in_n,
                        paper_out_in,
                        printer_online_in,
                        printer_fault_in_n,
                        2'b00,
                        enh_cycle_timeout_flag};

  status_capture u_status (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .capture     (rd_start && hit && ofs == OFS_STATUS),
    .live_status (live_status),
    .held_status (held_status)
  );

  epp_cycle_timer u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tif     (tif.tmr)
  );

  assign tif.run = (epp_state == EPP_BUSY);

  // Previous strobe and acknowledge levels for edge detection
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      ack_q <= 1'b1;
    end else begin
      wr_q  <= wr_act;
      rd_q  <= rd_act;
      ack_q <= printer_ack_in_n;
    end
  end

  // Data port takes the byte when the write strobe is released
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      printer_data_out <= DATA_RESET;
    end else if (wr_end && hit && ofs == OFS_DATA) begin
      printer_data_out <= host_data_in;
    end
  end

  // Control port: only six bits exist, the top two are wired low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      printer_line_control <= CONTROL_RESET;
    end else if (wr_end && hit && ofs == OFS_CONTROL) begin
      printer_line_control <= host_data_in[CTL_W-1:0];
    end
  end

  // Timeout flag; an expiry in the clearing cycle wins over the clear.
  // Other status bits written by the host are simply dropped.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      enh_cycle_timeout_flag <= 1'b0;
    end else if (epp_state == EPP_BUSY && !peripheral_wait_n && tif.expired) begin
      enh_cycle_timeout_flag <= 1'b1;
    end else if (wr_end && hit && ofs == OFS_STATUS && host_data_in[ST_TIMEOUT]) begin
      enh_cycle_timeout_flag <= 1'b0;
    end
  end

  // Enhanced-cycle sequencer: hold the host off until the peripheral
  // releases wait or the watchdog gives up on it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      epp_state        <= EPP_IDLE;
      enh_is_write     <= 1'b0;
      enh_out          <= EPP_RESET;
      enh_in           <= EPP_RESET;
      io_channel_ready <= 1'b1;
    end else begin
      unique case (epp_state)
        EPP_IDLE: begin
          if (enh_go) begin
            epp_state        <= EPP_BUSY;
            enh_is_write     <= wr_start;
            io_channel_ready <= 1'b0;
            if (wr_start) begin
              enh_out <= host_data_in;
            end
          end
        end
        EPP_BUSY: begin
          if (peripheral_wait_n) begin
            epp_state        <= EPP_HOLD;
            io_channel_ready <= 1'b1;
            if (!enh_is_write) begin
              enh_in <= cable_data_in;
            end
          end else if (tif.expired) begin
            epp_state        <= EPP_HOLD;
            io_channel_ready <= 1'b1;
          end
        end
        EPP_HOLD: begin
          if (!wr_act && !rd_act) begin
            epp_state <= EPP_IDLE;
          end
        end
      endcase
    end
  end

  // Host read data; data port reads follow the cable every cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      host_data_out <= 8'h00;
      host_data_oe  <= 1'b0;
    end else if (rd_act && answers) begin
      host_data_oe <= 1'b1;
      if (ofs == OFS_DATA) begin
        host_data_out <= cable_data_in;
      end else if (ofs == OFS_STATUS) begin
        host_data_out <= rd_start ? live_status : held_status;
      end else if (ofs == OFS_CONTROL) begin
        host_data_out <= {2'b00, printer_line_control};
      end else begin
        host_data_out <= enh_in;
      end
    end else begin
      host_data_out <= 8'h00;
      host_data_oe  <= 1'b0;
    end
  end

  // Cable data and direction; printer mode always drives out
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cable_data_out <= DATA_RESET;
      cable_data_oe  <= 1'b1;
    end else begin
      if (epp_state != EPP_IDLE && enh_is_write) begin
        cable_data_out <= enh_out;
      end else begin
        cable_data_out <= printer_data_out;
      end
      if (port_mode == MODE_PRINTER) begin
        cable_data_oe <= 1'b1;
      end else if (epp_state != EPP_IDLE) begin
        cable_data_oe <= enh_is_write;
      end else begin
        cable_data_oe <= !printer_line_control[CTL_DIR];
      end
    end
  end

  // Control lines to the cable, each through its own flip-flop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_strobe_out_n    <= !CONTROL_RESET[CTL_STROBE];
      auto_linefeed_out_n  <= !CONTROL_RESET[CTL_AUTO_LINEFEED_BIT];
      printer_init_n       <= CONTROL_RESET[CTL_INIT];
      select_printer_out_n <= !CONTROL_RESET[CTL_SELECT];
    end else begin
      data_strobe_out_n    <= !printer_line_control[CTL_STROBE];
      auto_linefeed_out_n  <= !printer_line_control[CTL_AUTO_LINEFEED_BIT];
      printer_init_n       <= printer_line_control[CTL_INIT];
      select_printer_out_n <= !printer_line_control[CTL_SELECT];
    end
  end

  // One pulse per acknowledge release, only while enabled
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_irq <= 1'b0;
    end else begin
      ack_irq <= printer_line_control[CTL_IRQ_EN] && printer_ack_in_n && !ack_q;
    end
  end

  a_data_to_cable: assert property (
    (wr_end && hit && ofs == OFS_DATA && epp_state == EPP_IDLE) ##1 (epp_state == EPP_IDLE)
      |=> cable_data_out == $past(host_data_in, 2)
  ) else $error("data port byte did not reach the cable");

  a_enh_refused: assert property (
    (port_mode != MODE_EPP && rd_act && hit && enh_port) |=> !host_data_oe
  ) else $error("enhanced port answered outside enhanced mode");

  a_status_zero_bits: assert property (
    $past(rd_act && hit && ofs == OFS_STATUS) |-> host_data_out[2:1] == 2'b00 && host_data_oe
  ) else $error("status bits 1 and 2 not zero");

  a_status_ready_bit: assert property (
    (rd_start && hit && ofs == OFS_STATUS) |=> host_data_out[ST_READY] == !$past(printer_busy_in)
  ) else $error("status bit 7 not the inverse of busy");

  a_ctl_top_zero: assert property (
    $past(rd_act && hit && ofs == OFS_CONTROL) |-> host_data_out[7:6] == 2'b00
  ) else $error("control bits 6 and 7 not zero");

  a_strobe_line: assert property (
    (wr_end && hit && ofs == OFS_CONTROL) |=> ##1 data_strobe_out_n == !$past(host_data_in[CTL_STROBE], 2)
  ) else $error("strobe line not inverse of control bit 0");

  a_init_line: assert property (
    (wr_end && hit && ofs == OFS_CONTROL) |=> ##1 printer_init_n == $past(host_data_in[CTL_INIT], 2)
  ) else $error("init line not equal to control bit 2");

  a_ack_irq_edge: assert property (
    (printer_line_control[CTL_IRQ_EN] && printer_ack_in_n && !ack_q) |=> ack_irq
  ) else $error("acknowledge edge raised no interrupt");

  a_ack_irq_off: assert property (
    !printer_line_control[CTL_IRQ_EN] |=> !ack_irq
  ) else $error("interrupt while disabled");

  a_timeout_abort: assert property (
    (epp_state == EPP_BUSY && !peripheral_wait_n && tif.expired)
      |=> enh_cycle_timeout_flag && io_channel_ready && epp_state == EPP_HOLD
  ) else $error("expired cycle not aborted with timeout");

  a_timeout_clear: assert property (
    (wr_end && hit && ofs == OFS_STATUS && host_data_in[ST_TIMEOUT] && epp_state != EPP_BUSY)
      |=> !enh_cycle_timeout_flag
  ) else $error("writing one did not clear timeout");

  a_printer_dir: assert property (
    (port_mode == MODE_PRINTER) |=> cable_data_oe
  ) else $error("printer mode not driving cable");

endmodule : printer_port_registers

// ### hw/status_capture.sv
/*
  Holds the status byte stable for the length of a host read.
  Assumes capture is a one-cycle pulse at the start of a status read.
*/
`timescale 1ns/1ps
module status_capture (
  input  wire logic       sys_clk,      // System clock
  input  wire logic       rst,          // Async reset, active high
  input  wire logic       capture,      // Pulse at read start
  input  wire logic [7:0] live_status,  // Status as seen now
  output      logic [7:0] held_status   // Frozen copy
);

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Freeze the byte so a line changing mid-read cannot tear it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      held_status <= 8'h00;
    end else if (capture) begin
      held_status <= live_status;
    end
  end

  a_status_hold: assert property (
    capture ##1 !capture |-> ##1 $stable(held_status) && held_status == $past(live_status, 2)
  ) else $error("status byte not held after capture");

endmodule : status_capture
